// *** bpm_pkg.sv ***
// Shared constants, types and layouts for the battery monitor page memory.
package bpm_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ          = 250000;
    localparam int CLK_HZ           = 250000000;
    localparam int NV_COPY_MIN_MS   = 2;
    localparam int NV_COPY_MAX_MS   = 10;
    localparam int NV_COPY_CYCLES   = NV_COPY_MAX_MS * CLK_KHZ;
    localparam int SECOND_CYCLES    = CLK_HZ;

    // ------------------------------------------------------------------
    // Memory organisation
    // ------------------------------------------------------------------
    localparam int PAGE_BYTES       = 8;
    localparam int PAGE_COUNT       = 8;
    localparam int MEM_BYTES        = PAGE_BYTES * PAGE_COUNT;
    localparam int CRC_INDEX        = 8;
    localparam logic [7:0] CRC_POLY_REFLECTED = 8'h8C;
    localparam logic [7:0] RESERVED_READ      = 8'hFF;

    localparam logic [2:0] PAGE_MEASURE   = 3'h0;
    localparam logic [2:0] PAGE_TIMER     = 3'h1;
    localparam logic [2:0] PAGE_STAMP     = 3'h2;
    localparam logic [2:0] PAGE_USER_LAST = 3'h7;

    // Byte addresses inside the 64-byte map.
    localparam logic [5:0] ADDR_STATUS_CONFIGURATION = 6'h00;
    localparam logic [5:0] ADDR_TEMPERATURE_LOW      = 6'h01;
    localparam logic [5:0] ADDR_TEMPERATURE_HIGH     = 6'h02;
    localparam logic [5:0] ADDR_VOLTAGE_LOW          = 6'h03;
    localparam logic [5:0] ADDR_VOLTAGE_HIGH         = 6'h04;
    localparam logic [5:0] ADDR_CURRENT_LOW          = 6'h05;
    localparam logic [5:0] ADDR_CURRENT_HIGH         = 6'h06;
    localparam logic [5:0] ADDR_THRESHOLD            = 6'h07;
    localparam logic [5:0] ADDR_ELAPSED_SECONDS      = 6'h08;
    localparam logic [5:0] ADDR_INTEGRATED_CURRENT   = 6'h0C;
    localparam logic [5:0] ADDR_CURRENT_OFFSET_LOW   = 6'h0D;
    localparam logic [5:0] ADDR_CURRENT_OFFSET_HIGH  = 6'h0E;
    localparam logic [5:0] ADDR_DISCONNECT_TIME      = 6'h10;
    localparam logic [5:0] ADDR_CHARGE_END_TIME      = 6'h14;
    localparam logic [5:0] ADDR_CHARGE_TOTAL         = 6'h3C;
    localparam logic [5:0] ADDR_DISCHARGE_TOTAL      = 6'h3E;

    // ------------------------------------------------------------------
    // Status/configuration field positions and reset value
    // ------------------------------------------------------------------
    localparam int CFG_CURRENT_SAMPLING  = 0;
    localparam int CFG_ACCUMULATOR       = 1;
    localparam int CFG_SHADOW            = 2;
    localparam int CFG_SUPPLY_SELECT     = 3;
    localparam int CFG_TEMPERATURE_BUSY  = 4;
    localparam int CFG_NONVOLATILE_BUSY  = 5;
    localparam int CFG_CONVERSION_BUSY   = 6;
    localparam logic [7:0] CFG_RESET     = 8'h0F;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h0F;
    localparam logic [7:0] THRESHOLD_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Command carrier from the bus protocol engine
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BPM_OP_WRITE,
        BPM_OP_READ,
        BPM_OP_COPY,
        BPM_OP_RECALL
    } bpm_op_e;

    typedef struct packed {
        logic       valid;
        bpm_op_e    op;
        logic [2:0] page;
        logic [3:0] index;
        logic [7:0] data;
    } bpm_cmd_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } bpm_result_s;

endpackage : bpm_pkg

// *** bpm_page_memory.sv ***
// Paged scratchpad and backing memory with configuration and busy flags.
// Notes on behaviour
// R1 - 64 bytes, eight pages, per-page scratchpad
// R2 - Write scratchpad, read back, copy to page
// R3 - Ninth scratchpad read byte returns CRC
// R4 - Page 0 byte 0 holds configuration
// R5 - Current sampling enable, default one
// R6 - Accumulators live in page 7 bytes 4-7
// R7 - Shadow increments to EEPROM when accumulating
// R8 - Voltage input select, default supply
// R9 - Temperature busy flag follows conversion
// R10 - Nonvolatile busy during EEPROM copy
// R11 - Conversion busy flag follows voltage conversion
// R12 - Page 0 holds measurement results, threshold
// R13 - Other page 0 bytes are read-only
// R14 - Scratchpad config and threshold drive operation
// R15 - Page 1 timer, accumulator, offset layout
// R16 - Page 1 byte 7 reads all ones
// R17 - Page 2 holds two writable timestamps
// R18 - Pages 3-7 are 40 user bytes
// R19 - Master avoids page 7 writes when accumulating
// R20 - Slave only, open-drain bus pin
// R21 - Timer snapshot taken at recall
// R22 - CRC x8+x5+x4+1, zero start, LSB first
// R23 - Copies skip read-only scratchpad locations
`timescale 1ns/100ps
module bpm_page_memory
    import bpm_pkg::*;
#(
    parameter int NV_CYCLES  = NV_COPY_CYCLES,
    parameter int SEC_CYCLES = SECOND_CYCLES
)(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire bpm_cmd_s    cmd_i,
    input  wire bpm_result_s temperature_i,
    input  wire bpm_result_s voltage_i,
    input  wire bpm_result_s current_i,
    input  wire logic        temperature_busy_flag_i,
    input  wire logic        conversion_busy_flag_i,
    input  wire logic        ica_valid_i,
    input  wire logic [7:0]  integrated_current_accum_i,
    input  wire logic        accum_valid_i,
    input  wire logic [15:0] charge_accum_total_i,
    input  wire logic [15:0] discharge_accum_total_i,
    input  wire logic        disconnect_event_i,
    input  wire logic        charge_end_event_i,
    input  wire logic        drive_low_i,
    input  wire logic        dq_i,
    output logic             dq_o,
    output logic             dq_oe_n_o,
    output logic             dq_sync_o,
    output logic             rvalid_o,
    output logic [7:0]       rdata_o,
    output logic             current_sampling_enable_o,
    output logic             accumulator_enable_o,
    output logic             accumulator_shadow_active_o,
    output logic             supply_select_o,
    output logic [7:0]       threshold_o,
    output logic [15:0]      current_offset_o,
    output logic [31:0]      elapsed_seconds_counter_o,
    output logic             nonvolatile_busy_flag_o
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    localparam int NV_W  = $clog2(NV_CYCLES + 1);
    localparam int SEC_W = $clog2(SEC_CYCLES + 1);

    typedef enum logic {
        BPM_NV_IDLE,
        BPM_NV_WRITE
    } bpm_nv_e;

    // R1 - eight scratchpads and pages
    logic [7:0]       sp  [MEM_BYTES];
    logic [7:0]       mem [MEM_BYTES];
    logic [31:0]      elapsed_seconds_counter;
    logic [SEC_W-1:0] sec_cnt;
    logic [NV_W-1:0]  nv_cnt;
    bpm_nv_e          nv_state;
    logic             dq_meta;
    logic             dq_sync;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    wire logic [5:0] cmd_addr   = {cmd_i.page, cmd_i.index[2:0]};
    wire logic       cmd_inpage = (cmd_i.index < 4'(PAGE_BYTES));
    wire logic       do_write   = cmd_i.valid && (cmd_i.op == BPM_OP_WRITE) && cmd_inpage;
    wire logic       do_read    = cmd_i.valid && (cmd_i.op == BPM_OP_READ);
    wire logic       do_recall  = cmd_i.valid && (cmd_i.op == BPM_OP_RECALL);
    wire logic       nv_busy    = (nv_state == BPM_NV_WRITE);
    wire logic       do_copy    = cmd_i.valid && (cmd_i.op == BPM_OP_COPY) && !nv_busy;
    // R18 - EEPROM pages start busy
    wire logic       copy_nv    = do_copy && (cmd_i.page != PAGE_STAMP);
    wire logic       cfg_ca     = sp[ADDR_STATUS_CONFIGURATION][CFG_ACCUMULATOR];
    wire logic       cfg_ee     = sp[ADDR_STATUS_CONFIGURATION][CFG_SHADOW];
    wire logic       sec_tick   = (sec_cnt == SEC_W'(SEC_CYCLES - 1));

    // R13 - locations the master may change
    function automatic logic writable(input logic [2:0] page, input logic [2:0] idx);
        logic w;
        w = 1'b1;
        if (page == PAGE_MEASURE)
            w = (idx == ADDR_STATUS_CONFIGURATION[2:0]) || (idx == ADDR_THRESHOLD[2:0]);
        else if (page == PAGE_TIMER)
            w = (idx != 3'h7);
        return w;
    endfunction : writable

    // R22 - reflected CRC, zero seed
    function automatic logic [7:0] crc8(input logic [63:0] bytes);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = 0; i < 64; i++)
        begin
            fb = c[0] ^ bytes[i];
            c  = c >> 1;
            if (fb)
                c = c ^ CRC_POLY_REFLECTED;
        end
        return c;
    endfunction : crc8

    // ------------------------------------------------------------------
    // Read view of the selected scratchpad
    // ------------------------------------------------------------------
    logic [63:0] view;
    genvar g;
    generate
        for (g = 0; g < PAGE_BYTES; g++)
        begin : g_view
            wire logic [5:0] a = {cmd_i.page, 3'(g)};
            wire logic [7:0] b = sp[a];
            wire logic       is_cfg = (cmd_i.page == PAGE_MEASURE) && (g == 0);
            wire logic       is_rsv = (cmd_i.page == PAGE_TIMER) && (g == 7);
            // R4 - live busy flags in the configuration byte
            // R9 - temperature busy flag
            // R11 - conversion busy flag
            // R16 - reserved byte reads ones
            assign view[g*8 +: 8] = is_rsv ? RESERVED_READ :
                                    is_cfg ? {b[7], conversion_busy_flag_i, nv_busy,
                                              temperature_busy_flag_i, b[3:0]} : b;
        end
    endgenerate

    wire logic [7:0] view_crc  = crc8(view);
    wire logic [7:0] read_byte = (cmd_i.index == 4'(CRC_INDEX)) ? view_crc :
                                 (cmd_i.index < 4'(PAGE_BYTES)) ? view[cmd_i.index[2:0]*8 +: 8] : RESERVED_READ;

    // ------------------------------------------------------------------
    // Scratchpads
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < MEM_BYTES; i++)
                sp[i] <= 8'h00;
            sp[ADDR_STATUS_CONFIGURATION] <= CFG_RESET;
        end
        else if (do_write)
        begin
            // R2 - master fills the scratchpad
            if (cmd_addr == ADDR_STATUS_CONFIGURATION)
                sp[cmd_addr] <= cmd_i.data & CFG_WRITE_MASK;
            else
                sp[cmd_addr] <= cmd_i.data;
        end
        else if (do_recall)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
                sp[{cmd_i.page, 3'(i)}] <= mem[{cmd_i.page, 3'(i)}];
            // R21 - timer snapshot into holding bytes
            if (cmd_i.page == PAGE_TIMER)
                for (int i = 0; i < 4; i++)
                    sp[ADDR_ELAPSED_SECONDS + 6'(i)] <= elapsed_seconds_counter[i*8 +: 8];
        end
    end

    // ------------------------------------------------------------------
    // Backing pages
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < MEM_BYTES; i++)
                mem[i] <= 8'h00;
            mem[ADDR_STATUS_CONFIGURATION] <= CFG_RESET;
            mem[ADDR_THRESHOLD]            <= THRESHOLD_RESET;
        end
        else
        begin
            // R23 - copy only writable bytes
            if (do_copy)
                for (int i = 0; i < PAGE_BYTES; i++)
                    if (writable(cmd_i.page, 3'(i)))
                        mem[{cmd_i.page, 3'(i)}] <= sp[{cmd_i.page, 3'(i)}];
            // R12 - measurement results into page 0
            if (temperature_i.valid)
                {mem[ADDR_TEMPERATURE_HIGH], mem[ADDR_TEMPERATURE_LOW]} <= temperature_i.value;
            if (voltage_i.valid)
                {mem[ADDR_VOLTAGE_HIGH], mem[ADDR_VOLTAGE_LOW]} <= voltage_i.value;
            if (current_i.valid)
                {mem[ADDR_CURRENT_HIGH], mem[ADDR_CURRENT_LOW]} <= current_i.value;
            // R15 - integrated accumulator byte
            if (ica_valid_i)
                mem[ADDR_INTEGRATED_CURRENT] <= integrated_current_accum_i;
            // R17 - timestamps from the running counter
            if (disconnect_event_i)
                for (int i = 0; i < 4; i++)
                    mem[ADDR_DISCONNECT_TIME + 6'(i)] <= elapsed_seconds_counter[i*8 +: 8];
            if (charge_end_event_i)
                for (int i = 0; i < 4; i++)
                    mem[ADDR_CHARGE_END_TIME + 6'(i)] <= elapsed_seconds_counter[i*8 +: 8];
            // R6 - accumulators kept in page 7
            // R7 - shadowed only when accumulating
            if (accum_valid_i && cfg_ca && cfg_ee)
            begin
                {mem[ADDR_CHARGE_TOTAL + 6'h1], mem[ADDR_CHARGE_TOTAL]}       <= charge_accum_total_i;
                {mem[ADDR_DISCHARGE_TOTAL + 6'h1], mem[ADDR_DISCHARGE_TOTAL]} <= discharge_accum_total_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Elapsed seconds counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sec_cnt <= '0;
            elapsed_seconds_counter     <= 32'h0000_0000;
        end
        else
        begin
            sec_cnt <= sec_tick ? '0 : sec_cnt + SEC_W'(1);
            // R15 - host may set the counter
            if (do_copy && (cmd_i.page == PAGE_TIMER))
                elapsed_seconds_counter <= {sp[ADDR_ELAPSED_SECONDS + 6'h3], sp[ADDR_ELAPSED_SECONDS + 6'h2],
                        sp[ADDR_ELAPSED_SECONDS + 6'h1], sp[ADDR_ELAPSED_SECONDS]};
            else if (sec_tick)
                elapsed_seconds_counter <= elapsed_seconds_counter + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Nonvolatile copy timing
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nv_state <= BPM_NV_IDLE;
            nv_cnt   <= '0;
        end
        else
        begin
            // R10 - busy for the whole EEPROM write
            case (nv_state)
                BPM_NV_IDLE:
                begin
                    if (copy_nv)
                    begin
                        nv_state <= BPM_NV_WRITE;
                        nv_cnt   <= NV_W'(NV_CYCLES);
                    end
                end
                BPM_NV_WRITE:
                begin
                    nv_cnt <= nv_cnt - NV_W'(1);
                    if (nv_cnt == NV_W'(1))
                        nv_state <= BPM_NV_IDLE;
                end
                default:
                    nv_state <= BPM_NV_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs and bus pin
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rvalid_o                    <= 1'b0;
            rdata_o                     <= 8'h00;
            current_sampling_enable_o   <= 1'b1;
            accumulator_enable_o        <= 1'b1;
            accumulator_shadow_active_o <= 1'b1;
            supply_select_o             <= 1'b1;
            threshold_o                 <= THRESHOLD_RESET;
            current_offset_o            <= 16'h0000;
            elapsed_seconds_counter_o   <= 32'h0000_0000;
            nonvolatile_busy_flag_o     <= 1'b0;
        end
        else
        begin
            // R3 - data bytes then CRC
            rvalid_o                    <= do_read;
            rdata_o                     <= do_read ? read_byte : rdata_o;
            // R14 - scratchpad config and threshold steer the device
            // R5 - current sampling enable
            current_sampling_enable_o   <= sp[ADDR_STATUS_CONFIGURATION][CFG_CURRENT_SAMPLING];
            accumulator_enable_o        <= cfg_ca;
            accumulator_shadow_active_o <= cfg_ca && cfg_ee;
            // R8 - voltage input select
            supply_select_o             <= sp[ADDR_STATUS_CONFIGURATION][CFG_SUPPLY_SELECT];
            threshold_o                 <= sp[ADDR_THRESHOLD];
            current_offset_o            <= {mem[ADDR_CURRENT_OFFSET_HIGH], mem[ADDR_CURRENT_OFFSET_LOW]};
            elapsed_seconds_counter_o   <= elapsed_seconds_counter;
            nonvolatile_busy_flag_o     <= nv_busy;
        end
    end

    // R20 - open-drain slave pin
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dq_o      <= 1'b0;
            dq_oe_n_o <= 1'b1;
            dq_meta   <= 1'b1;
            dq_sync   <= 1'b1;
            dq_sync_o <= 1'b1;
        end
        else
        begin
            dq_o      <= 1'b0;
            dq_oe_n_o <= !drive_low_i;
            dq_meta   <= dq_i;
            dq_sync   <= dq_meta;
            dq_sync_o <= dq_sync;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_crc_byte;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        do_read && (cmd_i.index == 4'(CRC_INDEX)) |=> rvalid_o && (rdata_o == $past(view_crc));
    endproperty
    a_crc_byte: assert property (p_crc_byte) else $error("crc byte wrong"); // R3

    property p_reserved_ones;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        do_read && (cmd_i.page == PAGE_TIMER) && (cmd_i.index == 4'h7) |=> rdata_o == RESERVED_READ;
    endproperty
    a_reserved_ones: assert property (p_reserved_ones) else $error("reserved byte not ones"); // R16

    property p_temp_busy;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        do_read && (cmd_i.page == PAGE_MEASURE) && (cmd_i.index == 4'h0)
            |=> rdata_o[CFG_TEMPERATURE_BUSY] == $past(temperature_busy_flag_i)
                && rdata_o[CFG_CONVERSION_BUSY] == $past(conversion_busy_flag_i);
    endproperty
    a_temp_busy: assert property (p_temp_busy) else $error("busy flag mismatch"); // R9

    property p_nv_start;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        copy_nv |=> ##1 nonvolatile_busy_flag_o;
    endproperty
    a_nv_start: assert property (p_nv_start) else $error("nv busy not raised"); // R10

    property p_nv_end;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        nv_busy && (nv_cnt == NV_W'(1)) |=> !nv_busy ##1 !nonvolatile_busy_flag_o;
    endproperty
    a_nv_end: assert property (p_nv_end) else $error("nv busy not released"); // R10

    property p_cfg_follow;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 current_sampling_enable_o == $past(sp[ADDR_STATUS_CONFIGURATION][CFG_CURRENT_SAMPLING]);
    endproperty
    a_cfg_follow: assert property (p_cfg_follow) else $error("config not from scratchpad"); // R14

    property p_shadow_gated;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        accum_valid_i && !(cfg_ca && cfg_ee) && !do_copy |=> $stable(mem[ADDR_CHARGE_TOTAL]);
    endproperty
    a_shadow_gated: assert property (p_shadow_gated) else $error("shadow without accumulators"); // R7

    property p_ro_kept;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        do_copy && (cmd_i.page == PAGE_MEASURE) && !temperature_i.valid |=> $stable(mem[ADDR_TEMPERATURE_LOW]);
    endproperty
    a_ro_kept: assert property (p_ro_kept) else $error("read-only byte overwritten"); // R23

    property p_snapshot;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        do_recall && (cmd_i.page == PAGE_TIMER) |=> sp[ADDR_ELAPSED_SECONDS] == $past(elapsed_seconds_counter[7:0]);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("timer snapshot missing"); // R21

    property p_open_drain;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 (dq_oe_n_o == !$past(drive_low_i)) && !dq_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin drive wrong"); // R20

endmodule : bpm_page_memory

// *** bpm_master_model.sv ***
// Bus master model that issues memory commands and resolves the pulled-up data line.
`timescale 1ns/100ps
module bpm_master_model
    import bpm_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic dq_oe_n_i,
    output bpm_cmd_s  cmd_o,
    output logic      dq_level_o
);
    assign dq_level_o = dq_oe_n_i;
    initial cmd_o = '0;
    task automatic issue(input bpm_op_e op, input logic [2:0] pg, input logic [3:0] ix, input logic [7:0] d);
        @(posedge core_clk_i);
        cmd_o <= '{1'b1, op, pg, ix, d};
        @(posedge core_clk_i);
        cmd_o.valid <= 1'b0;
        #1;
    endtask : issue
endmodule : bpm_master_model

// *** battery_monitor_page_memory_test.sv ***
// Self-checking bench for the battery monitor page memory.
`timescale 1ns/100ps
module battery_monitor_page_memory_test
    import bpm_pkg::*;
;
    logic        core_clk_i, rst_n_i, drive_low_i, dq_level, rvalid_o, dq_o, dq_oe_n_o, dq_sync_o;
    logic        cse, ace, sha, sup, nonvolatile_busy_flag;
    logic [1:0]  busy;
    logic [3:0]  ev;
    logic [7:0]  integrated_current_accum, t, rdata_o, threshold_o;
    logic [7:0]  r = 8'h29;
    logic [31:0] acc;
    logic [47:0] m;
    logic [63:0] b;
    bpm_result_s tmp, vlt, cur;
    bpm_cmd_s    cmd;
    int          n_mismatch, n_tests;
    logic [15:0] ofs;
    logic [31:0] secs;
    int          cyc, cc, stamp;

    bpm_page_memory #(.NV_CYCLES(8), .SEC_CYCLES(4)) u_bpm_page_memory (
        .core_clk_i, .rst_n_i, .cmd_i(cmd), .temperature_i(tmp), .voltage_i(vlt), .current_i(cur),
        .temperature_busy_flag_i(busy[0]), .conversion_busy_flag_i(busy[1]), .ica_valid_i(ev[0]),
        .integrated_current_accum_i(integrated_current_accum), .accum_valid_i(ev[1]), .charge_accum_total_i(acc[15:0]),
        .discharge_accum_total_i(acc[31:16]), .disconnect_event_i(ev[2]), .charge_end_event_i(ev[3]),
        .drive_low_i, .dq_i(dq_level), .dq_o, .dq_oe_n_o, .dq_sync_o, .rvalid_o, .rdata_o,
        .current_sampling_enable_o(cse), .accumulator_enable_o(ace), .accumulator_shadow_active_o(sha),
        .supply_select_o(sup), .threshold_o, .current_offset_o(ofs), .elapsed_seconds_counter_o(secs),
        .nonvolatile_busy_flag_o(nonvolatile_busy_flag));
    bpm_master_model u_bpm_master_model (.core_clk_i, .dq_oe_n_i(dq_oe_n_o), .cmd_o(cmd), .dq_level_o(dq_level));
    // Counts edges since reset release; the seconds counter ticks every fourth one.
    always @(posedge core_clk_i) cyc <= rst_n_i ? cyc + 1 : 0;

    function automatic logic [7:0] rnd();
        r = {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
        return r;
    endfunction : rnd
    function automatic logic [7:0] crc8(input logic [63:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 64; i++)
            c = (c[0] ^ v[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
        return c;
    endfunction : crc8
    task automatic chk8(input logic [7:0] s, input logic [7:0] e, input string nm);
        n_tests++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk8
    task automatic chk1(input logic s, input logic e, input string nm);
        chk8({7'h00, s}, {7'h00, e}, nm);
    endtask : chk1
    task automatic go(input bpm_op_e o, input logic [2:0] pg, input logic [3:0] ix, input logic [7:0] d);
        u_bpm_master_model.issue(o, pg, ix, d);
    endtask : go
    task automatic rd(input logic [2:0] pg, input logic [3:0] ix, input logic [7:0] e);
        go(BPM_OP_READ, pg, ix, 8'h00);
        chk1(rvalid_o, 1'b1, "rvalid");
        chk8(rdata_o, e, "rdata");
    endtask : rd
    task automatic copy(input logic [2:0] pg);
        go(BPM_OP_COPY, pg, 4'h0, 8'h00);
        cc = cyc;
        repeat (8) @(posedge core_clk_i);
        #1 chk1(nonvolatile_busy_flag, 1'b1, "nv_busy");
        @(posedge core_clk_i);
        #1 chk1(nonvolatile_busy_flag, 1'b0, "nv_idle");
    endtask : copy
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        {rst_n_i, drive_low_i, busy, ev, integrated_current_accum, acc, tmp, vlt, cur} = '0;
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        #1 chk1(cse & ace & sha & sup, 1'b1, "cfg_reset");
        chk8(threshold_o, 8'h00, "threshold_reset");
        rd(3'h0, 4'h0, 8'h0F);
        @(posedge core_clk_i);
        busy <= 2'b11;
        rd(3'h0, 4'h0, 8'h5F);
        busy <= 2'b00;
        // Random user page, read back, then its check byte.
        for (int i = 0; i < 8; i++)
        begin
            b[8*i+:8] = rnd();
            go(BPM_OP_WRITE, 3'h3, 4'(i), b[8*i+:8]);
        end
        for (int i = 0; i < 8; i++)
            rd(3'h3, 4'(i), b[8*i+:8]);
        rd(3'h3, 4'h8, crc8(b));
        copy(3'h3);
        go(BPM_OP_WRITE, 3'h3, 4'h0, ~b[7:0]);
        go(BPM_OP_RECALL, 3'h3, 4'h0, 8'h00);
        for (int i = 0; i < 8; i++)
            rd(3'h3, 4'(i), b[8*i+:8]);
        rd(3'h1, 4'h7, 8'hFF);
        // Measurement, accumulator and event pulses together.
        for (int i = 0; i < 6; i++)
            m[8*i+:8] = rnd();
        acc = {rnd(), rnd(), rnd(), rnd()};
        t = rnd();
        @(posedge core_clk_i);
        {tmp, vlt, cur} <= {1'b1, m[15:0], 1'b1, m[31:16], 1'b1, m[47:32]};
        {ev, integrated_current_accum} <= {4'hF, t};
        @(posedge core_clk_i);
        {tmp.valid, vlt.valid, cur.valid, ev} <= '0;
        #1 stamp = (cyc - 1) / 4;
        go(BPM_OP_WRITE, 3'h0, 4'h1, 8'hAA);
        copy(3'h0);
        go(BPM_OP_RECALL, 3'h0, 4'h0, 8'h00);
        for (int i = 1; i < 7; i++)
            rd(3'h0, 4'(i), m[8*(i-1)+:8]);
        go(BPM_OP_RECALL, 3'h1, 4'h0, 8'h00);
        rd(3'h1, 4'h4, t);
        go(BPM_OP_RECALL, 3'h7, 4'h0, 8'h00);
        for (int i = 4; i < 8; i++)
            rd(3'h7, 4'(i), acc[8*(i-4)+:8]);
        go(BPM_OP_RECALL, 3'h2, 4'h0, 8'h00);
        for (int i = 0; i < 8; i++)
            rd(3'h2, 4'(i), 8'(stamp >> (8 * (i % 4))));
        t = rnd();
        go(BPM_OP_WRITE, 3'h0, 4'h7, t);
        go(BPM_OP_WRITE, 3'h0, 4'h0, 8'hF0);
        @(posedge core_clk_i);
        #1 chk8(threshold_o, t, "threshold");
        chk1(cse | ace | sha | sup, 1'b0, "cfg_clear");
        chk8(secs[7:0], 8'((cyc - 1) / 4), "seconds");
        rd(3'h0, 4'h0, 8'h00);
        // Accumulator pulse with accumulation off must leave page 7 alone.
        ev[1] <= 1'b1;
        acc   <= ~acc;
        @(posedge core_clk_i);
        ev[1] <= 1'b0;
        go(BPM_OP_RECALL, 3'h7, 4'h0, 8'h00);
        rd(3'h7, 4'h4, ~acc[7:0]);
        // Host sets counter and offset through a page 1 copy.
        for (int i = 0; i < 7; i++)
        begin
            b[8*i+:8] = rnd();
            go(BPM_OP_WRITE, 3'h1, 4'(i), b[8*i+:8]);
        end
        copy(3'h1);
        chk8(ofs[15:8], b[55:48], "offset_high");
        chk8(ofs[7:0], b[47:40], "offset_low");
        chk8(secs[7:0], 8'(b[31:0] + (cyc - 1) / 4 - cc / 4), "seconds_set");
        @(posedge core_clk_i);
        drive_low_i <= 1'b1;
        @(posedge core_clk_i);
        #1 chk1(dq_oe_n_o, 1'b0, "pin_drive");
        repeat (4) @(posedge core_clk_i);
        #1 chk1(dq_sync_o | dq_o, 1'b0, "pin_level");
        report_and_stop();
    end
endmodule : battery_monitor_page_memory_test
